/* File: ckdv_top.sv */
`timescale 1ns/1ps
module ckdv_top #(
  parameter int WAKE_PD_CYCLES = ckdv_pkg::RST_TIMEOUT_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // register port
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // core control and straps
  input wire logic sleep_arm_bit,
  input wire logic [2:0] sleep_mode_select,
  input wire logic sleep_instr,
  input wire logic timer0_async_select,
  input wire logic xtal_source_sel,
  input wire logic adc_enable,
  input wire logic [7:0] sig_row_trim,
  // wake-up sources
  input wire logic irq_any,
  input wire logic [3:0] ext_irq_low_lines,
  input wire logic [3:0] ext_irq_high_lines,
  input wire logic twi_addr_match,
  input wire logic timer0_irq,
  input wire logic spm_ready_irq,
  input wire logic adc_irq,
  // clock domain enables
  output logic cpu_clock,
  output logic flash_clock,
  output logic io_clock,
  output logic adc_clock,
  output logic async_clock,
  output logic main_osc_en,
  output logic timer_osc_en,
  // oscillator trim and sleep status
  output logic [7:0] trim_value,
  output logic adc_start,
  output logic cpu_stall,
  output logic irq_dispatch,
  output logic sleeping
);

  // ==========================================================================
  // decoding functions
  // ==========================================================================
  function automatic logic [2:0] eff_mode(input logic [2:0] sel, input logic xtal);
    logic [2:0] m;
    m = sel;
    if (sel == 3'h4 || sel == 3'h5)
      m = ckdv_pkg::MODE_IDLE;
    else if (sel == ckdv_pkg::MODE_STDBY && !xtal)
      m = ckdv_pkg::MODE_PDOWN;
    else if (sel == ckdv_pkg::MODE_XSTDBY && !xtal)
      m = ckdv_pkg::MODE_PSAVE;
    return m;
  endfunction

  // gate order: cpu, flash, io, adc, async, osc, tosc
  function automatic logic [6:0] gate(input logic [2:0] m, input logic as0);
    logic [6:0] g;
    g = 7'h00;
    case (m)
      ckdv_pkg::MODE_IDLE:
        g = {2'b00, 3'b111, 1'b1, as0};
      ckdv_pkg::MODE_ADCNR:
        g = {3'b000, 2'b11, 1'b1, as0};
      ckdv_pkg::MODE_PDOWN:
        g = 7'h00;
      ckdv_pkg::MODE_PSAVE:
        g = {4'b0000, as0, 1'b0, as0};
      ckdv_pkg::MODE_STDBY:
        g = {5'b00000, 1'b1, 1'b0};
      ckdv_pkg::MODE_XSTDBY:
        g = {4'b0000, as0, 1'b1, as0};
      default:
        g = 7'h00;
    endcase
    return g;
  endfunction

  function automatic logic wake_src(input logic [2:0] m, input logic as0, input logic any,
                                    input logic lim, input logic t0, input logic spm,
                                    input logic adc);
    logic w;
    w = lim;
    case (m)
      ckdv_pkg::MODE_IDLE:
        w = any || lim || t0 || spm || adc;
      ckdv_pkg::MODE_ADCNR:
        w = lim || t0 || spm || adc;
      ckdv_pkg::MODE_PSAVE, ckdv_pkg::MODE_XSTDBY:
        w = lim || (as0 && t0);
      default:
        w = lim;
    endcase
    return w;
  endfunction

  function automatic logic [ckdv_pkg::WAIT_W-1:0] wake_wait(input logic [2:0] m);
    int c;
    c = 0;
    case (m)
      ckdv_pkg::MODE_PDOWN, ckdv_pkg::MODE_PSAVE:
        c = WAKE_PD_CYCLES;
      ckdv_pkg::MODE_STDBY, ckdv_pkg::MODE_XSTDBY:
        c = ckdv_pkg::STDBY_WAKE_CYCLES;
      default:
        c = 0;
    endcase
    return ckdv_pkg::WAIT_W'(c + ckdv_pkg::WAKE_STALL_CYCLES - 1);
  endfunction

  // ==========================================================================
  // state
  // ==========================================================================
  ckdv_pkg::ckdv_state_s st_reg;
  ckdv_pkg::ckdv_state_s st_next;
  logic [7:0] period;
  logic tick;
  logic lim_irq;
  logic [6:0] g;
  logic [2:0] m_new;

  assign period = ckdv_pkg::DIV_BASE - {1'b0, st_reg.factor};
  assign lim_irq = (|ext_irq_low_lines) || (|ext_irq_high_lines) || twi_addr_match;
  assign m_new = eff_mode(sleep_mode_select, xtal_source_sel);

  always_comb
  begin
    st_next = st_reg;
    st_next.adc_start = 1'b0;
    st_next.irq_go = 1'b0;
    st_next.rdata = ckdv_pkg::RDATA_UNMAPPED;
    g = 7'h7f;
    tick = 1'b0;

    // register writes
    if (reg_wr && reg_addr == ckdv_pkg::DIV_OFFSET)
    begin
      if (reg_wdata[ckdv_pkg::DIV_EN_BIT])
      begin
        if (!st_reg.div_en)
          st_next.factor = reg_wdata[6:0];
        st_next.div_en = 1'b1;
      end
      else
        st_next.div_en = 1'b0;
    end
    if (!st_reg.trim_loaded)
    begin
      st_next.trim = sig_row_trim;
      st_next.trim_loaded = 1'b1;
    end
    else if (reg_wr && reg_addr == ckdv_pkg::TRIM_OFFSET)
      st_next.trim = reg_wdata;

    // register reads
    if (reg_rd && reg_addr == ckdv_pkg::DIV_OFFSET)
      st_next.rdata = {st_reg.div_en, st_reg.factor};
    else if (reg_rd && reg_addr == ckdv_pkg::TRIM_OFFSET)
      st_next.rdata = st_reg.trim;

    // divider: whole-cycle enable pulses, restarted on any factor change
    if (!st_next.div_en || st_next.factor != st_reg.factor)
      st_next.div_cnt = 8'h00;
    else if (st_reg.div_cnt >= period - 8'h01)
      st_next.div_cnt = 8'h00;
    else
      st_next.div_cnt = st_reg.div_cnt + 8'h01;
    tick = !st_next.div_en || st_next.div_cnt == 8'h00;

    // sleep sequencing
    case (st_reg.state)
      ckdv_pkg::ST_RUN:
      begin
        if (sleep_instr && sleep_arm_bit)
        begin
          st_next.state = ckdv_pkg::ST_SLEEP;
          st_next.mode = m_new;
          st_next.adc_start = adc_enable &&
            (m_new == ckdv_pkg::MODE_IDLE || m_new == ckdv_pkg::MODE_ADCNR);
        end
      end
      ckdv_pkg::ST_SLEEP:
      begin
        if (wake_src(st_reg.mode, timer0_async_select, irq_any, lim_irq, timer0_irq,
                     spm_ready_irq, adc_irq))
        begin
          st_next.state = ckdv_pkg::ST_WAKE;
          st_next.wait_cnt = wake_wait(st_reg.mode);
        end
      end
      ckdv_pkg::ST_WAKE:
      begin
        if (st_reg.wait_cnt == '0)
        begin
          st_next.state = ckdv_pkg::ST_RUN;
          st_next.irq_go = 1'b1;
        end
        else
          st_next.wait_cnt = st_reg.wait_cnt - 1'b1;
      end
      default:
        st_next.state = ckdv_pkg::ST_RUN;
    endcase

    // gating; memories are never touched, only their clocks stop
    if (st_next.state == ckdv_pkg::ST_SLEEP)
      g = gate(st_next.mode, timer0_async_select);
    else if (st_next.state == ckdv_pkg::ST_WAKE)
      g = {2'b00, 5'b11111};
    else
      g = {6'b111111, timer0_async_select};
    st_next.cpu_en = g[6] && tick;
    st_next.flash_en = g[5] && tick;
    st_next.io_en = g[4] && tick;
    st_next.adc_en = g[3] && tick;
    st_next.async_en = g[2];
    st_next.osc_en = g[1];
    st_next.tosc_en = g[0];
    st_next.cpu_stall = st_next.state == ckdv_pkg::ST_WAKE;
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_reg <= '0;
      st_reg.state <= ckdv_pkg::ST_RUN;
      st_reg.div_en <= ckdv_pkg::DIV_RESET[ckdv_pkg::DIV_EN_BIT];
      st_reg.factor <= ckdv_pkg::DIV_RESET[6:0];
      st_reg.trim <= ckdv_pkg::TRIM_RESET;
      st_reg.mode <= ckdv_pkg::MODE_IDLE;
    end
    else
      st_reg <= st_next;
  end

  assign reg_rdata = st_reg.rdata;
  assign cpu_clock = st_reg.cpu_en;
  assign flash_clock = st_reg.flash_en;
  assign io_clock = st_reg.io_en;
  assign adc_clock = st_reg.adc_en;
  assign async_clock = st_reg.async_en;
  assign main_osc_en = st_reg.osc_en;
  assign timer_osc_en = st_reg.tosc_en;
  assign trim_value = st_reg.trim;
  assign adc_start = st_reg.adc_start;
  assign cpu_stall = st_reg.cpu_stall;
  assign irq_dispatch = st_reg.irq_go;
  assign sleeping = st_reg.state == ckdv_pkg::ST_SLEEP;

  // ==========================================================================
  // assertions
  // ==========================================================================
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  logic [7:0] gap_cnt;
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      gap_cnt <= 8'h00;
    else if (io_clock)
      gap_cnt <= 8'h00;
    else if (gap_cnt != 8'hff)
      gap_cnt <= gap_cnt + 8'h01;
  end

  a_div_period: assert property (
    io_clock && $past(io_clock) == 1'b0 && st_reg.div_en && st_reg.state == ckdv_pkg::ST_RUN &&
    $stable(st_reg.factor) && $past(st_reg.div_en) && $past(st_reg.div_en, 2) &&
    $past(st_reg.state) == ckdv_pkg::ST_RUN && gap_cnt != 8'hff
    |-> gap_cnt == period - 8'h01 || $past(gap_cnt) == 8'h00)
    else $error("divided clock period wrong");
  a_factor_load: assert property (
    reg_wr && reg_addr == ckdv_pkg::DIV_OFFSET && reg_wdata[7] && !st_reg.div_en
    |=> st_reg.div_en && st_reg.factor == $past(reg_wdata[6:0]))
    else $error("factor not captured");
  a_factor_drop: assert property (
    reg_wr && reg_addr == ckdv_pkg::DIV_OFFSET && !reg_wdata[7]
    |=> !st_reg.div_en && $stable(st_reg.factor))
    else $error("factor changed on disable");
  a_trim_boot: assert property (
    $rose(st_reg.trim_loaded) |-> trim_value == $past(sig_row_trim))
    else $error("trim not loaded at reset");
  a_idle_gating: assert property (
    sleeping && st_reg.mode == ckdv_pkg::MODE_IDLE && !st_reg.div_en
    |-> !cpu_clock && !flash_clock && io_clock && adc_clock && main_osc_en)
    else $error("idle gating wrong");
  a_pdown_gating: assert property (
    sleeping && st_reg.mode == ckdv_pkg::MODE_PDOWN
    |-> !(cpu_clock || io_clock || adc_clock || async_clock || main_osc_en))
    else $error("power-down left a clock running");
  a_async_select: assert property (
    sleeping && !timer0_async_select && $stable(timer0_async_select) &&
    (st_reg.mode == ckdv_pkg::MODE_PSAVE || st_reg.mode == ckdv_pkg::MODE_XSTDBY)
    |-> !async_clock && !timer_osc_en)
    else $error("async clock without select");
  a_idle_stall: assert property (
    sleeping && st_reg.mode == ckdv_pkg::MODE_IDLE && irq_any
    |=> cpu_stall [*4] ##1 (irq_dispatch && !cpu_stall))
    else $error("idle wake stall not four cycles");
  a_adc_kick: assert property (
    st_reg.state == ckdv_pkg::ST_RUN && sleep_instr && sleep_arm_bit && adc_enable &&
    m_new == ckdv_pkg::MODE_IDLE |=> adc_start)
    else $error("no adc start on idle");
  a_xtal_need: assert property (
    sleeping && !$past(xtal_source_sel) && $past(st_reg.state) == ckdv_pkg::ST_RUN
    |-> st_reg.mode != ckdv_pkg::MODE_STDBY && st_reg.mode != ckdv_pkg::MODE_XSTDBY)
    else $error("standby entered without crystal");

  c_idle_wake: cover property (sleeping ##1 cpu_stall ##[1:10] irq_dispatch);
  c_div_on: cover property (st_reg.div_en && io_clock ##1 !io_clock);
  c_stdby: cover property (sleeping && st_reg.mode == ckdv_pkg::MODE_STDBY);

endmodule

/* File: ckdv_pkg.sv */
package ckdv_pkg;

  // ==========================================================================
  // register port
  // ==========================================================================
  localparam logic [5:0] TRIM_OFFSET = 6'h31;
  localparam logic [5:0] DIV_OFFSET = 6'h3c;
  localparam int DIV_EN_BIT = 7;
  localparam logic [7:0] DIV_RESET = 8'h00;
  localparam logic [7:0] TRIM_RESET = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
  localparam logic [7:0] DIV_BASE = 8'h81;

  // ==========================================================================
  // sleep mode select codes
  // ==========================================================================
  localparam logic [2:0] MODE_IDLE = 3'h0;
  localparam logic [2:0] MODE_ADCNR = 3'h1;
  localparam logic [2:0] MODE_PDOWN = 3'h2;
  localparam logic [2:0] MODE_PSAVE = 3'h3;
  localparam logic [2:0] MODE_STDBY = 3'h6;
  localparam logic [2:0] MODE_XSTDBY = 3'h7;

  // ==========================================================================
  // timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 10;
  localparam int WAKE_STALL_CYCLES = 4;
  localparam int STDBY_WAKE_CYCLES = 6;
  localparam int RST_TIMEOUT_US = 4100;
  localparam int RST_TIMEOUT_CYCLES = RST_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
  localparam int WAIT_W = 20;

  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_SLEEP = 3'b010,
    ST_WAKE = 3'b100
  } ckdv_state_e;

  typedef struct packed {
    ckdv_state_e state;
    logic div_en;
    logic [6:0] factor;
    logic [7:0] div_cnt;
    logic [7:0] trim;
    logic trim_loaded;
    logic [2:0] mode;
    logic [WAIT_W-1:0] wait_cnt;
    logic cpu_en;
    logic flash_en;
    logic io_en;
    logic adc_en;
    logic async_en;
    logic osc_en;
    logic tosc_en;
    logic adc_start;
    logic cpu_stall;
    logic irq_go;
    logic [7:0] rdata;
  } ckdv_state_s;

endpackage

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  // ==========================================================================
  // stimulus and observed signals
  // ==========================================================================
  typedef struct packed {logic [5:0] a; logic [7:0] wd; logic [7:0] rd; logic [7:0] per;} ckdv_tb_reg_s;
  typedef struct packed {logic [2:0] mode; logic [2:0] cfg; logic [6:0] gate; logic ast;
    logic [2:0] src; logic deep; logic [1:0] wk;} ckdv_tb_row_s;
  logic mclk, nrst, reg_wr, reg_rd, sleep_arm_bit, sleep_instr, timer0_async_select;
  logic xtal_source_sel, adc_enable, irq_any, twi_addr_match, timer0_irq, spm_ready_irq, adc_irq;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, sig_row_trim, trim_value, d;
  logic [2:0] sleep_mode_select;
  logic [3:0] ext_irq_low_lines, ext_irq_high_lines;
  logic cpu_clock, flash_clock, io_clock, adc_clock, async_clock, main_osc_en, timer_osc_en;
  logic adc_start, cpu_stall, irq_dispatch, sleeping;
  int n_mismatch = 0;
  int compares = 0;
  // register rows: address, write data, read-back, divided period (0 = skip)
  localparam ckdv_tb_reg_s rr [8] = '{{6'h3c, 8'h85, 8'h85, 8'h7c}, {6'h3c, 8'h9f, 8'h85, 8'h7c},
    {6'h3c, 8'h3f, 8'h05, 8'h01}, {6'h3c, 8'hff, 8'hff, 8'h02}, {6'h3c, 8'h00, 8'h7f, 8'h01},
    {6'h3c, 8'h80, 8'h80, 8'h81}, {6'h31, 8'ha5, 8'ha5, 8'h00}, {6'h10, 8'hff, 8'h00, 8'h00}};
  // sleep rows: cfg = {async select, crystal, adc enable}, wk = wake class
  localparam ckdv_tb_row_s sr [11] = '{{3'h0, 3'h7, 7'h1f, 1'h1, 3'h0, 1'h0, 2'h0},
    {3'h1, 3'h7, 7'h0f, 1'h1, 3'h6, 1'h1, 2'h0}, {3'h2, 3'h6, 7'h00, 1'h0, 3'h3, 1'h1, 2'h2},
    {3'h3, 3'h6, 7'h05, 1'h0, 3'h4, 1'h1, 2'h2}, {3'h6, 3'h6, 7'h02, 1'h0, 3'h2, 1'h1, 2'h1},
    {3'h7, 3'h6, 7'h07, 1'h0, 3'h4, 1'h1, 2'h1}, {3'h4, 3'h7, 7'h1f, 1'h1, 3'h0, 1'h0, 2'h0},
    {3'h5, 3'h6, 7'h1f, 1'h0, 3'h1, 1'h0, 2'h0}, {3'h3, 3'h2, 7'h00, 1'h0, 3'h1, 1'h1, 2'h2},
    {3'h6, 3'h4, 7'h00, 1'h0, 3'h3, 1'h1, 2'h2},
    {3'h1, 3'h7, 7'h0f, 1'h1, 3'h5, 1'h1, 2'h0}};

  ckdv_top #(.WAKE_PD_CYCLES(8)) ckdv_top_i (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sleep_arm_bit(sleep_arm_bit), .sleep_mode_select(sleep_mode_select),
    .sleep_instr(sleep_instr), .timer0_async_select(timer0_async_select),
    .xtal_source_sel(xtal_source_sel), .adc_enable(adc_enable), .sig_row_trim(sig_row_trim),
    .irq_any(irq_any), .ext_irq_low_lines(ext_irq_low_lines),
    .ext_irq_high_lines(ext_irq_high_lines), .twi_addr_match(twi_addr_match),
    .timer0_irq(timer0_irq), .spm_ready_irq(spm_ready_irq), .adc_irq(adc_irq),
    .cpu_clock(cpu_clock), .flash_clock(flash_clock), .io_clock(io_clock),
    .adc_clock(adc_clock), .async_clock(async_clock), .main_osc_en(main_osc_en),
    .timer_osc_en(timer_osc_en), .trim_value(trim_value), .adc_start(adc_start),
    .cpu_stall(cpu_stall), .irq_dispatch(irq_dispatch), .sleeping(sleeping));

  // ==========================================================================
  // tasks
  // ==========================================================================
  task close_out;
    if (n_mismatch == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task hang;
    n_mismatch++;
    close_out;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    v = reg_rdata;
  endtask

  // cycles between two io clock pulses
  task automatic period(input logic [7:0] exp);
    int n;
    n = 0;
    do
    begin
      @(negedge mclk);
      n++;
    end while (io_clock !== 1'b1 && n < 300);
    if (n >= 300)
      hang();
    chk({5'h0, cpu_clock, flash_clock, adc_clock}, 8'h07);
    n = 0;
    do
    begin
      @(negedge mclk);
      n++;
    end while (io_clock !== 1'b1 && n < 300);
    if (n >= 300)
      hang();
    chk(n[7:0], exp);
  endtask

  task automatic set_src(input logic [2:0] s, input logic v);
    case (s)
      3'h0: irq_any <= v;
      3'h1: ext_irq_low_lines <= {3'h0, v};
      3'h2: ext_irq_high_lines <= {v, 3'h0};
      3'h3: twi_addr_match <= v;
      3'h4: timer0_irq <= v;
      3'h5: spm_ready_irq <= v;
      default: adc_irq <= v;
    endcase
  endtask

  task automatic run_row(input ckdv_tb_row_s r);
    int k;
    int st;
    logic [7:0] n;
    st = ckdv_pkg::WAKE_STALL_CYCLES;
    if (r.wk == 2'h1)
      st = st + ckdv_pkg::STDBY_WAKE_CYCLES;
    if (r.wk == 2'h2)
      st = st + 8;
    @(posedge mclk);
    sleep_mode_select <= r.mode;
    {timer0_async_select, xtal_source_sel, adc_enable} <= r.cfg;
    @(posedge mclk);
    sleep_instr <= 1'b1;
    @(posedge mclk);
    sleep_instr <= 1'b0;
    @(negedge mclk);
    chk({6'h0, sleeping, adc_start}, {7'h1, r.ast});
    @(negedge mclk);
    chk({1'h0, cpu_clock, flash_clock, io_clock, adc_clock, async_clock, main_osc_en,
      timer_osc_en}, {1'h0, r.gate});
    if (r.deep)
    begin
      @(posedge mclk);
      irq_any <= 1'b1;
      repeat (3) @(posedge mclk);
      irq_any <= 1'b0;
      @(negedge mclk);
      chk({7'h0, sleeping}, 8'h01);
    end
    @(posedge mclk);
    set_src(r.src, 1'b1);
    k = 0;
    n = 8'h00;
    while (irq_dispatch !== 1'b1 && k < 100)
    begin
      @(negedge mclk);
      k++;
      if (cpu_stall === 1'b1 && irq_dispatch !== 1'b1)
        n++;
    end
    if (k >= 100)
      hang();
    chk(n, st[7:0]);
    chk({7'h0, sleeping}, 8'h00);
    @(posedge mclk);
    set_src(r.src, 1'b0);
  endtask

  // ==========================================================================
  // clock and main sequence
  // ==========================================================================
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial
  begin
    {nrst, reg_wr, reg_rd, sleep_arm_bit, sleep_instr, irq_any, twi_addr_match} = 7'h00;
    {timer0_irq, spm_ready_irq, adc_irq, xtal_source_sel} = 4'h0;
    // timer0 runs from its async clock while the divider is in use
    timer0_async_select = 1'b1;
    adc_enable = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
    sleep_mode_select = 3'h0;
    ext_irq_low_lines = 4'h0;
    ext_irq_high_lines = 4'h0;
    sig_row_trim = 8'h5a;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    chk(trim_value, ckdv_pkg::TRIM_RESET);
    @(posedge mclk);
    nrst <= 1'b1;
    repeat (2) @(negedge mclk);
    chk(trim_value, 8'h5a);
    rd(ckdv_pkg::DIV_OFFSET, d);
    chk(d, ckdv_pkg::DIV_RESET);
    foreach (rr[i])
    begin
      wr(rr[i].a, rr[i].wd);
      rd(rr[i].a, d);
      chk(d, rr[i].rd);
      if (rr[i].a == ckdv_pkg::TRIM_OFFSET)
        chk(trim_value, rr[i].wd);
      if (rr[i].per != 8'h00)
        period(rr[i].per);
    end
    wr(ckdv_pkg::DIV_OFFSET, 8'h00);
    // sleep instruction without the arm bit must be ignored
    @(posedge mclk);
    sleep_instr <= 1'b1;
    @(posedge mclk);
    sleep_instr <= 1'b0;
    repeat (2) @(negedge mclk);
    chk({7'h0, sleeping}, 8'h00);
    @(posedge mclk);
    sleep_arm_bit <= 1'b1;
    foreach (sr[i])
      run_row(sr[i]);
    rd(ckdv_pkg::TRIM_OFFSET, d);
    chk(d, 8'ha5);
    // reset while asleep restarts in run with a fresh trim load
    @(posedge mclk);
    sleep_mode_select <= ckdv_pkg::MODE_PDOWN;
    sleep_instr <= 1'b1;
    @(posedge mclk);
    sleep_instr <= 1'b0;
    @(negedge mclk);
    chk({7'h0, sleeping}, 8'h01);
    @(posedge mclk);
    nrst <= 1'b0;
    sig_row_trim <= 8'hc3;
    @(negedge mclk);
    chk({7'h0, sleeping}, 8'h00);
    @(posedge mclk);
    nrst <= 1'b1;
    repeat (2) @(negedge mclk);
    chk(trim_value, 8'hc3);
    chk({4'h0, cpu_clock, flash_clock, io_clock, sleeping}, 8'h0e);
    close_out;
  end
endmodule
